// ==== logic/gxo_cb_table.sv ====
// Context bank configuration store with a registered read port.
// Assumes writes and reads on the same clock; out-of-range reads give 0.
`timescale 1ns/1ps
module gxo_cb_table #(
  parameter int DEPTH = 12,
  parameter int IDX_W = 4,
  parameter int W = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Write port
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [W-1:0] rd_data
);
  import gxo_pkg::*;

  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] next_rd_data;

  always_comb begin
    next_rd_data = '0;
    if (int'(rd_idx) < DEPTH) begin
      next_rd_data = mem[rd_idx];
    end
  end

  // Array holds no reset so it can map onto plain storage
  always_ff @(posedge sys_clk) begin
    if (wr_en && int'(wr_idx) < DEPTH) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule : gxo_cb_table

// ==== logic/gxo_desc_check.sv ====
// Combinational descriptor check for one table lookup.
// Assumes the caller supplies the access kind of the running operation.
`timescale 1ns/1ps
module gxo_desc_check (
  // Descriptor and access
  input wire logic [gxo_pkg::DATA_W-1:0] desc,
  input wire logic is_stage2,
  input wire logic is_user,
  input wire logic is_write,
  // Verdict
  output logic fault,
  output logic [gxo_pkg::FT_W-1:0] fault_type
);
  import gxo_pkg::*;

  always_comb begin
    fault_type = FT_NONE;
    if (!desc[DESC_VALID_BIT]) begin
      fault_type = FT_TRANSLATION;
    end else if (is_write && !desc[DESC_WRITE_BIT]) begin
      fault_type = FT_PERMISSION;
    end else if (!is_stage2 && is_user && !desc[DESC_USER_BIT]) begin
      // Stage 2 has no privilege notion, only stage 1 checks user
      fault_type = FT_PERMISSION;
    end
    fault = (fault_type != FT_NONE);
  end

endmodule : gxo_desc_check

// ==== logic/gxo_pkg.sv ====
// Shared constants, types and helpers for the global translation unit.
// Assumes one 32-bit address space for requests, tables and results.
package gxo_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int PAGE_SHIFT = 12;
  localparam int DESC_SHIFT = 2;
  localparam int OP_W = 3;
  localparam int FT_W = 5;
  localparam int NUM_COPY = 2;

  ////////////////////////////////////////////////////////////////////////
  // Operation code: nested, privileged, write
  localparam int OP_NESTED_BIT = 2;
  localparam int OP_PRIV_BIT = 1;
  localparam int OP_WRITE_BIT = 0;
  localparam logic [2:0] OP_S1_USER_READ = 3'h0;
  localparam logic [2:0] OP_S1_USER_WRITE = 3'h1;
  localparam logic [2:0] OP_S1_PRIV_READ = 3'h2;
  localparam logic [2:0] OP_S1_PRIV_WRITE = 3'h3;
  localparam logic [2:0] OP_NESTED_USER_READ = 3'h4;
  localparam logic [2:0] OP_NESTED_USER_WRITE = 3'h5;
  localparam logic [2:0] OP_NESTED_PRIV_READ = 3'h6;
  localparam logic [2:0] OP_NESTED_PRIV_WRITE = 3'h7;

  // Security copies
  localparam bit COPY_NS = 1'b0;
  localparam bit COPY_S = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // Context bank configuration word
  localparam int CFG_S2_FMT_BIT = 1;
  localparam int CFG_SECURE_BIT = 2;
  localparam int CFG_LINKED_BIT = 3;
  localparam int CFG_FAULT_CTX_BIT = 4;
  localparam int CFG_S2IDX_LSB = 8;
  localparam logic [DATA_W-1:0] CFG_RST = 32'h0000_0000;

  // Table descriptor
  localparam int DESC_VALID_BIT = 0;
  localparam int DESC_USER_BIT = 1;
  localparam int DESC_WRITE_BIT = 2;

  ////////////////////////////////////////////////////////////////////////
  // Result word
  localparam int RES_FAULT_BIT = 0;
  localparam int RES_TYPE_LSB = 1;
  localparam int RES_STAGE_BIT = 6;
  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
  localparam logic [FT_W-1:0] FT_NONE = 5'h00;
  localparam logic [FT_W-1:0] FT_UNIMPL_CB = 5'h01;
  localparam logic [FT_W-1:0] FT_INVALID_CTX = 5'h02;
  localparam logic [FT_W-1:0] FT_TRANSLATION = 5'h03;
  localparam logic [FT_W-1:0] FT_PERMISSION = 5'h04;
  localparam logic [FT_W-1:0] FT_EXT_ABORT = 5'h05;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CB_RD = 3'b001,
    ST_CB_CHK = 3'b010,
    ST_S2_CHK = 3'b011,
    ST_WALK = 3'b100,
    ST_PF = 3'b101,
    ST_DONE = 3'b110
  } gxo_state_t;

  typedef enum logic [1:0] {
    PH_TBL_S2 = 2'b00,
    PH_S1 = 2'b01,
    PH_OUT_S2 = 2'b10
  } gxo_phase_t;

  // Descriptor address: one word per page of the input address
  function automatic logic [ADDR_W-1:0] desc_addr(
    input logic [ADDR_W-1:0] base,
    input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] idx;
    idx = ADDR_W'({a[ADDR_W-1:PAGE_SHIFT], {DESC_SHIFT{1'b0}}});
    return {base[ADDR_W-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}} + idx;
  endfunction : desc_addr

  function automatic logic [ADDR_W-1:0] page_join(
    input logic [DATA_W-1:0] desc,
    input logic [ADDR_W-1:0] a);
    return {desc[ADDR_W-1:PAGE_SHIFT], a[PAGE_SHIFT-1:0]};
  endfunction : page_join

  function automatic logic [DATA_W-1:0] fault_word(
    input logic stage2,
    input logic [FT_W-1:0] ft);
    logic [DATA_W-1:0] w;
    w = RESULT_RST;
    w[RES_FAULT_BIT] = 1'b1;
    w[RES_TYPE_LSB +: FT_W] = ft;
    w[RES_STAGE_BIT] = stage2;
    return w;
  endfunction : fault_word

endpackage : gxo_pkg

// ==== logic/gxo_top.sv ====
// Global translation operation unit: secure and non-secure request copies,
// one shared table walker, one prefetch entry.
// Assumes requests, config writes and the walk port share sys_clk.
// Overview of operation
// - Eight ops: stage, privilege, read/write combos
// - Request write starts translation with address, bank
// - Missing or stage 2 bank: unimplemented fault
// - Non-secure copy accepts only non-secure banks
// - Secure and non-secure copies run independently
// - Secure software reaches non-secure copy by alias
// - Success loads address into issuing copy's result
// - Progress flag high from start to completion
// - Failure writes fault type and stage code
// - Never stall; faults only in result word
// - Never queued behind stalled client traffic
// - Linked bank: table address through stage 2
// - Linked to fault context: invalid context fault
// - Prefetch finishes before completion is reported
`timescale 1ns/1ps
module gxo_top #(
  parameter int NUM_CB = 12,
  parameter int CB_IDX_W = 4,
  parameter bit PF_EN = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Translation request strobe
  input wire logic req_valid,
  input wire logic req_from_secure,
  input wire logic req_alias_ns,
  input wire logic [gxo_pkg::OP_W-1:0] req_op,
  input wire logic [gxo_pkg::ADDR_W-1:0] req_addr,
  input wire logic [CB_IDX_W-1:0] req_cb,
  // Context bank configuration write
  input wire logic cfg_we,
  input wire logic [CB_IDX_W-1:0] cfg_idx,
  input wire logic [gxo_pkg::DATA_W-1:0] cfg_data,
  // Secure copy status
  output logic [gxo_pkg::DATA_W-1:0] secure_glob_xlate_result,
  output logic secure_glob_xlate_progress,
  // Non-secure copy status
  output logic [gxo_pkg::DATA_W-1:0] nonsecure_glob_xlate_result,
  output logic nonsecure_glob_xlate_progress,
  // Table walk read port
  output logic walk_req,
  output logic [gxo_pkg::ADDR_W-1:0] walk_addr,
  input wire logic walk_ack,
  input wire logic [gxo_pkg::DATA_W-1:0] walk_data,
  input wire logic walk_err
);
  import gxo_pkg::*;

  logic [NUM_COPY-1:0] take;
  logic [NUM_COPY-1:0] grant;
  logic [NUM_COPY-1:0] done;
  logic [NUM_COPY-1:0] active;
  logic [NUM_COPY-1:0] pend;
  logic [OP_W-1:0] q_op [NUM_COPY];
  logic [ADDR_W-1:0] q_addr [NUM_COPY];
  logic [CB_IDX_W-1:0] q_cb [NUM_COPY];
  logic [DATA_W-1:0] result [NUM_COPY];
  logic [DATA_W-1:0] fin_result;
  logic tgt_secure;

  ////////////////////////////////////////////////////////////////////////
  // Request routing
  assign tgt_secure = req_from_secure && !req_alias_ns;
  // Non-secure software can never reach the secure copy
  assign take[COPY_S] = req_valid && tgt_secure;
  assign take[COPY_NS] = req_valid && !tgt_secure;

  ////////////////////////////////////////////////////////////////////////
  // Per-copy request, progress and result state
  genvar g;
  for (g = 0; g < NUM_COPY; g++) begin : g_copy
    logic act_q, pend_q, next_act, next_pend;
    logic [OP_W-1:0] op_q, next_op;
    logic [ADDR_W-1:0] addr_q, next_addr;
    logic [CB_IDX_W-1:0] cb_q, next_cb;
    logic [DATA_W-1:0] res_q, next_res;

    always_comb begin
      next_act = act_q;
      next_pend = pend_q;
      next_op = op_q;
      next_addr = addr_q;
      next_cb = cb_q;
      next_res = res_q;
      if (done[g]) begin
        next_act = 1'b0;
        next_res = fin_result;
      end
      if (grant[g]) begin
        next_pend = 1'b0;
      end
      // A request while busy is undefined; latest one simply wins
      if (take[g]) begin
        next_act = 1'b1;
        next_pend = 1'b1;
        next_op = req_op;
        next_addr = req_addr;
        next_cb = req_cb;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        act_q <= 1'b0;
        pend_q <= 1'b0;
        op_q <= '0;
        addr_q <= '0;
        cb_q <= '0;
        res_q <= RESULT_RST;
      end else begin
        act_q <= next_act;
        pend_q <= next_pend;
        op_q <= next_op;
        addr_q <= next_addr;
        cb_q <= next_cb;
        res_q <= next_res;
      end
    end

    assign active[g] = act_q;
    assign pend[g] = pend_q;
    assign q_op[g] = op_q;
    assign q_addr[g] = addr_q;
    assign q_cb[g] = cb_q;
    assign result[g] = res_q;
  end

  assign secure_glob_xlate_result = result[COPY_S];
  assign secure_glob_xlate_progress = active[COPY_S];
  assign nonsecure_glob_xlate_result = result[COPY_NS];
  assign nonsecure_glob_xlate_progress = active[COPY_NS];

  ////////////////////////////////////////////////////////////////////////
  // Shared walker
  gxo_state_t state, next_state;
  gxo_phase_t phase, next_phase;
  logic cur, next_cur, last, next_last, sel;
  logic [OP_W-1:0] w_op, next_w_op;
  logic [ADDR_W-1:0] w_addr, next_w_addr;
  logic [CB_IDX_W-1:0] w_cb, next_w_cb;
  logic [ADDR_W-1:0] tmp_addr, next_tmp_addr;
  logic [ADDR_W-1:0] s2_ttb, next_s2_ttb;
  logic [ADDR_W-1:0] next_walk_addr;
  logic [DATA_W-1:0] wres, next_wres;
  logic pf_valid, next_pf_valid;
  logic [ADDR_W-1:0] pf_addr, next_pf_addr;
  logic [DATA_W-1:0] pf_desc, next_pf_desc;
  logic [CB_IDX_W-1:0] cb_rd_idx, s2_idx;
  logic [DATA_W-1:0] cb_rdata;
  logic pf_hit, eff_ack, chk_fault, stage2_ph;
  logic [DATA_W-1:0] eff_data;
  logic [FT_W-1:0] chk_type;

  assign s2_idx = cb_rdata[CFG_S2IDX_LSB +: CB_IDX_W];
  assign cb_rd_idx = (state == ST_CB_CHK) ? s2_idx : w_cb;
  assign stage2_ph = (phase != PH_S1);
  assign pf_hit = PF_EN && state == ST_WALK && phase == PH_S1 &&
                  pf_valid && pf_addr == walk_addr;
  // Dedicated port: never shares a queue with client traffic
  assign walk_req = (state == ST_WALK && !pf_hit) || state == ST_PF;
  assign eff_ack = walk_ack || pf_hit;
  assign eff_data = pf_hit ? pf_desc : walk_data;
  assign sel = (&pend) ? !last : pend[COPY_S];

  gxo_cb_table #(
    .DEPTH(NUM_CB),
    .IDX_W(CB_IDX_W),
    .W(DATA_W)
  ) u_cb_table (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .wr_en(cfg_we),
    .wr_idx(cfg_idx),
    .wr_data(cfg_data),
    .rd_idx(cb_rd_idx),
    .rd_data(cb_rdata)
  );

  gxo_desc_check u_desc_check (
    .desc(eff_data),
    .is_stage2(stage2_ph),
    .is_user(!w_op[OP_PRIV_BIT]),
    .is_write((phase != PH_TBL_S2) && w_op[OP_WRITE_BIT]),
    .fault(chk_fault),
    .fault_type(chk_type)
  );

  always_comb begin
    next_state = state;
    next_phase = phase;
    next_cur = cur;
    next_last = last;
    next_w_op = w_op;
    next_w_addr = w_addr;
    next_w_cb = w_cb;
    next_tmp_addr = tmp_addr;
    next_s2_ttb = s2_ttb;
    next_walk_addr = walk_addr;
    next_wres = wres;
    next_pf_valid = pf_valid;
    next_pf_addr = pf_addr;
    next_pf_desc = pf_desc;
    grant = '0;
    done = '0;
    case (state)
      ST_IDLE: begin
        if (|pend) begin
          grant[sel] = 1'b1;
          next_cur = sel;
          next_last = sel;
          next_w_op = q_op[sel];
          next_w_addr = q_addr[sel];
          next_w_cb = q_cb[sel];
          next_state = ST_CB_RD;
        end
      end
      ST_CB_RD: begin
        next_state = ST_CB_CHK;
      end
      ST_CB_CHK: begin
        next_state = ST_DONE;
        if (int'(w_cb) >= NUM_CB || cb_rdata[CFG_S2_FMT_BIT]) begin
          next_wres = fault_word(1'b0, FT_UNIMPL_CB);
        end else if (cur == COPY_NS && cb_rdata[CFG_SECURE_BIT]) begin
          next_wres = fault_word(1'b0, FT_UNIMPL_CB);
        end else if (cb_rdata[CFG_LINKED_BIT]) begin
          if (int'(s2_idx) >= NUM_CB) begin
            next_wres = fault_word(1'b1, FT_INVALID_CTX);
          end else begin
            next_tmp_addr = desc_addr(cb_rdata, w_addr);
            next_state = ST_S2_CHK;
          end
        end else if (w_op[OP_NESTED_BIT]) begin
          // Nested op on a bank with no second stage
          next_wres = fault_word(1'b1, FT_INVALID_CTX);
        end else begin
          next_walk_addr = desc_addr(cb_rdata, w_addr);
          next_phase = PH_S1;
          next_state = ST_WALK;
        end
      end
      ST_S2_CHK: begin
        next_state = ST_DONE;
        if (!cb_rdata[CFG_S2_FMT_BIT] || cb_rdata[CFG_FAULT_CTX_BIT]) begin
          next_wres = fault_word(1'b1, FT_INVALID_CTX);
        end else begin
          next_s2_ttb = cb_rdata;
          next_walk_addr = desc_addr(cb_rdata, tmp_addr);
          next_phase = PH_TBL_S2;
          next_state = ST_WALK;
        end
      end
      ST_WALK: begin
        if (eff_ack) begin
          if (walk_ack && walk_err) begin
            next_wres = fault_word(stage2_ph, FT_EXT_ABORT);
            next_state = ST_DONE;
          end else if (chk_fault) begin
            next_wres = fault_word(stage2_ph, chk_type);
            next_state = ST_DONE;
          end else begin
            case (phase)
              PH_TBL_S2: begin
                next_walk_addr = page_join(eff_data, tmp_addr);
                next_phase = PH_S1;
              end
              PH_S1: begin
                next_tmp_addr = page_join(eff_data, w_addr);
                if (w_op[OP_NESTED_BIT]) begin
                  next_walk_addr = desc_addr(s2_ttb,
                                             page_join(eff_data, w_addr));
                  next_phase = PH_OUT_S2;
                end else begin
                  next_wres = {eff_data[DATA_W-1:PAGE_SHIFT],
                               {PAGE_SHIFT{1'b0}}};
                  next_state = ST_DONE;
                  if (PF_EN) begin
                    next_walk_addr = walk_addr +
                                     ADDR_W'(1 << DESC_SHIFT);
                    next_pf_addr = walk_addr + ADDR_W'(1 << DESC_SHIFT);
                    next_pf_valid = 1'b0;
                    next_state = ST_PF;
                  end
                end
              end
              PH_OUT_S2: begin
                next_wres = {eff_data[DATA_W-1:PAGE_SHIFT],
                             {PAGE_SHIFT{1'b0}}};
                next_state = ST_DONE;
              end
              default: begin
                next_state = ST_DONE;
              end
            endcase
          end
        end
      end
      ST_PF: begin
        // Completion waits for the prefetch read to return
        if (walk_ack) begin
          next_pf_valid = !walk_err;
          next_pf_desc = walk_data;
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        done[cur] = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Config change may leave the prefetched entry stale
    if (cfg_we) begin
      next_pf_valid = 1'b0;
    end
  end

  assign fin_result = wres;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      phase <= PH_S1;
      cur <= COPY_NS;
      last <= COPY_NS;
      w_op <= '0;
      w_addr <= '0;
      w_cb <= '0;
      tmp_addr <= '0;
      s2_ttb <= '0;
      walk_addr <= '0;
      wres <= RESULT_RST;
      pf_valid <= 1'b0;
      pf_addr <= '0;
      pf_desc <= '0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      cur <= next_cur;
      last <= next_last;
      w_op <= next_w_op;
      w_addr <= next_w_addr;
      w_cb <= next_w_cb;
      tmp_addr <= next_tmp_addr;
      s2_ttb <= next_s2_ttb;
      walk_addr <= next_walk_addr;
      wres <= next_wres;
      pf_valid <= next_pf_valid;
      pf_addr <= next_pf_addr;
      pf_desc <= next_pf_desc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking ast_clk @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_op_decode;
    (state == ST_WALK && phase == PH_S1 && eff_ack && !walk_err &&
     !chk_fault && w_op[OP_NESTED_BIT]) |=>
      (state == ST_WALK && phase == PH_OUT_S2);
  endproperty
  a_op_decode: assert property (p_op_decode)
    else $error("nested op did not walk its output through stage 2");

  property p_progress_set;
    take[COPY_NS] |=> nonsecure_glob_xlate_progress;
  endproperty
  a_progress_set: assert property (p_progress_set)
    else $error("progress flag not set after request");

  property p_unimpl;
    (state == ST_CB_CHK && (int'(w_cb) >= NUM_CB ||
     cb_rdata[CFG_S2_FMT_BIT])) |=> (state == ST_DONE &&
     wres[RES_FAULT_BIT] && wres[RES_TYPE_LSB +: FT_W] == FT_UNIMPL_CB);
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("bad bank index not reported as unimplemented");

  property p_ns_secure_bank;
    (state == ST_CB_CHK && cur == COPY_NS && cb_rdata[CFG_SECURE_BIT])
      |=> (wres[RES_FAULT_BIT] && state == ST_DONE);
  endproperty
  a_ns_secure_bank: assert property (p_ns_secure_bank)
    else $error("non-secure copy used a secure bank");

  property p_indep;
    (!done[COPY_NS] && !take[COPY_NS]) |=>
      ($stable(nonsecure_glob_xlate_result) &&
       $stable(nonsecure_glob_xlate_progress));
  endproperty
  a_indep: assert property (p_indep)
    else $error("non-secure copy changed without its own event");

  property p_result_at_clear;
    done[COPY_S] |=> (!secure_glob_xlate_progress &&
      secure_glob_xlate_result == $past(fin_result));
  endproperty
  a_result_at_clear: assert property (p_result_at_clear)
    else $error("result not loaded when progress cleared");

  property p_abort_code;
    (state == ST_WALK && walk_ack && walk_err) |=> (state == ST_DONE &&
      wres[RES_TYPE_LSB +: FT_W] == FT_EXT_ABORT &&
      wres[RES_STAGE_BIT] == $past(stage2_ph));
  endproperty
  a_abort_code: assert property (p_abort_code)
    else $error("abort fault code or stage wrong");

  property p_no_stall;
    (state == ST_CB_RD) |-> ##[1:3] (state == ST_WALK || state == ST_DONE);
  endproperty
  a_no_stall: assert property (p_no_stall)
    else $error("checks did not finish in three cycles");

  property p_fault_ctx;
    (state == ST_S2_CHK && cb_rdata[CFG_FAULT_CTX_BIT]) |=>
      (state == ST_DONE && wres[RES_TYPE_LSB +: FT_W] == FT_INVALID_CTX);
  endproperty
  a_fault_ctx: assert property (p_fault_ctx)
    else $error("fault context link not reported invalid");

  property p_pf_before_done;
    (walk_req && !walk_ack) |=> (done == '0);
  endproperty
  a_pf_before_done: assert property (p_pf_before_done)
    else $error("completion reported with a read outstanding");

  c_s1_done: cover property (state == ST_PF ##1 state == ST_DONE);
  c_nested: cover property (phase == PH_OUT_S2 && eff_ack && !chk_fault);
  c_both_pend: cover property (pend == 2'b11);
  c_pf_hit: cover property (pf_hit);

endmodule : gxo_top

// ==== test/gxo_tb.sv ====
// Self-checking bench for gxo_top: drives requests and bank config,
// answers table reads itself. Assumes gxo_pkg and design files compiled.
`timescale 1ns/1ps
module tb;
  import gxo_pkg::*;
  localparam logic [31:0] FRAME = 32'h5A5A_5000;
  localparam logic [31:0] VA = 32'h0000_3123;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_from_secure = 1'b0;
  logic req_alias_ns = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic [3:0] req_cb = 4'h0;
  logic cfg_we = 1'b0;
  logic [3:0] cfg_idx = 4'h0;
  logic [31:0] cfg_data = 32'h0000_0000;
  logic [31:0] s_res, ns_res, walk_addr;
  logic s_prog, ns_prog, walk_req;
  logic walk_ack = 1'b0;
  logic [31:0] walk_data = 32'h0000_0000;
  logic walk_err = 1'b0;
  logic [11:0] dlow = 12'h007;
  logic werr = 1'b0;
  int wdly = 0;
  int wcnt = 0;
  int last_n = 0;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] seen[$];

  always #2.5 sys_clk = ~sys_clk;

  gxo_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid),
    .req_from_secure(req_from_secure), .req_alias_ns(req_alias_ns),
    .req_op(req_op), .req_addr(req_addr), .req_cb(req_cb),
    .cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_data(cfg_data),
    .secure_glob_xlate_result(s_res), .secure_glob_xlate_progress(s_prog),
    .nonsecure_glob_xlate_result(ns_res),
    .nonsecure_glob_xlate_progress(ns_prog), .walk_req(walk_req),
    .walk_addr(walk_addr), .walk_ack(walk_ack), .walk_data(walk_data),
    .walk_err(walk_err));

  ////////////////////////////////////////////////////////////////////////
  // Table reads answered after wdly cycles; data line scrambles otherwise
  always @(posedge sys_clk) begin
    if (walk_req && !walk_ack && wcnt >= wdly) begin
      walk_ack <= 1'b1;
      walk_err <= werr;
      walk_data <= FRAME | 32'(dlow);
      seen.push_back(walk_addr);
    end else begin
      walk_ack <= 1'b0;
      walk_err <= 1'b0;
      walk_data <= ~walk_data;
    end
    if (walk_req && !walk_ack && wcnt < wdly) begin
      wcnt <= wcnt + 1;
    end else begin
      wcnt <= 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [31:0] fw(logic st2, logic [4:0] ft);
    return {25'h0, st2, ft, 1'b1};
  endfunction : fw

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic cfg(logic [3:0] i, logic [31:0] d);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_data <= d;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
  endtask : cfg

  task automatic drive(logic sec, logic ali, logic [2:0] op, logic [31:0] a,
                       logic [3:0] cb);
    req_valid <= 1'b1;
    req_from_secure <= sec;
    req_alias_ns <= ali;
    req_op <= op;
    req_addr <= a;
    req_cb <= cb;
  endtask : drive

  // Bounded wait until neither copy is busy
  task automatic wait_idle();
    int n;
    n = 0;
    while ((s_prog | ns_prog) !== 1'b0 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    last_n = n;
    if (n >= 400) begin
      miscompares++;
      close_out();
    end
  endtask : wait_idle

  task automatic xlate(logic sec, logic ali, logic [2:0] op, logic [31:0] a,
                       logic [3:0] cb, logic [31:0] exp);
    logic tgt;
    logic [31:0] other;
    tgt = sec && !ali;
    other = tgt ? ns_res : s_res;
    @(posedge sys_clk);
    drive(sec, ali, op, a, cb);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("progress", 32'h1, 32'(tgt ? s_prog : ns_prog));
    wait_idle();
    check("result", exp, tgt ? s_res : ns_res);
    check("other copy", other, tgt ? ns_res : s_res);
  endtask : xlate

  ////////////////////////////////////////////////////////////////////////
  task automatic t_ops();
    for (int op = 0; op < 4; op++)
      xlate(1'b0, 1'b0, 3'(op), VA, 4'h0, FRAME);
    for (int op = 4; op < 8; op++)
      xlate(1'b0, 1'b0, 3'(op), VA, 4'h0, fw(1'b1, FT_INVALID_CTX));
  endtask : t_ops

  task automatic t_bank();
    xlate(1'b0, 1'b0, 3'h0, VA, 4'hC, fw(1'b0, FT_UNIMPL_CB));
    xlate(1'b1, 1'b0, 3'h0, VA, 4'h1, fw(1'b0, FT_UNIMPL_CB));
    xlate(1'b0, 1'b0, 3'h0, VA, 4'h2, fw(1'b0, FT_UNIMPL_CB));
    xlate(1'b1, 1'b0, 3'h0, VA, 4'h2, FRAME);
    xlate(1'b1, 1'b1, 3'h0, VA, 4'h0, FRAME);
  endtask : t_bank

  task automatic t_fault();
    dlow = 12'h000;
    xlate(1'b0, 1'b0, 3'h0, 32'h0009_0000, 4'h0,
          fw(1'b0, FT_TRANSLATION));
    dlow = 12'h005;
    xlate(1'b1, 1'b0, 3'h1, 32'h000B_0000, 4'h0,
          fw(1'b0, FT_PERMISSION));
    dlow = 12'h007;
    werr = 1'b1;
    xlate(1'b0, 1'b0, 3'h2, 32'h000D_0000, 4'h0,
          fw(1'b0, FT_EXT_ABORT));
    werr = 1'b0;
  endtask : t_fault

  task automatic t_nest();
    xlate(1'b0, 1'b0, 3'h0, VA, 4'h3, fw(1'b1, FT_INVALID_CTX));
    seen.delete();
    xlate(1'b0, 1'b0, 3'h0, VA, 4'h6, FRAME);
    check("s2 table read", 32'h0002_0040, seen[0]);
    check("s1 desc read", 32'h5A5A_500C, seen[1]);
    xlate(1'b1, 1'b0, 3'h4, VA, 4'h6, FRAME);
    seen.delete();
    xlate(1'b0, 1'b0, 3'h3, 32'h0002_1000, 4'h0, FRAME);
    check("reads done", 32'd2, 32'(seen.size()));
    // Next page hits the prefetched entry: only the new prefetch reads
    seen.delete();
    xlate(1'b0, 1'b0, 3'h0, 32'h0002_2000, 4'h0, FRAME);
    check("pf hit reads", 32'd1, 32'(seen.size()));
    check("next prefetch", 32'h0001_008C, seen[0]);
  endtask : t_nest

  // Both copies busy at once, slow walker on the non-secure one
  task automatic t_both();
    wdly = 20;
    @(posedge sys_clk);
    drive(1'b0, 1'b0, 3'h0, 32'h0000_5000, 4'h0);
    @(posedge sys_clk);
    drive(1'b1, 1'b0, 3'h0, VA, 4'hC);
    @(posedge sys_clk);
    req_valid <= 1'b0;
    @(posedge sys_clk);
    #1;
    check("both busy", 32'h3, 32'({s_prog, ns_prog}));
    wait_idle();
    check("ns slow", 32'h1, 32'(last_n > 20));
    check("ns result", FRAME, ns_res);
    check("s result", fw(1'b0, FT_UNIMPL_CB), s_res);
    wdly = 0;
  endtask : t_both

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    check("idle", 32'h0,
          s_res | ns_res | 32'({s_prog, ns_prog, walk_req}));
    cfg(4'h0, 32'h0001_0000);
    cfg(4'h1, 32'h0000_0002);
    cfg(4'h2, 32'h0001_0004);
    cfg(4'h3, 32'h0001_0408);
    cfg(4'h4, 32'h0000_0012);
    cfg(4'h5, 32'h0002_0002);
    cfg(4'h6, 32'h0001_0508);
    t_ops();
    t_bank();
    t_fault();
    t_nest();
    t_both();
    close_out();
  end
endmodule : tb
